// file: verilog/adc_port_pkg.sv
// Constants shared by the serial audio output port and its clock scaler.
// Assumes a single 40 MHz mclk domain and 7-bit register indices.
package adc_port_pkg;

  // Register indices on the control port
  localparam logic [6:0] FORMAT_REG_ADDR = 7'h04;
  localparam logic [6:0] CLK_REG_ADDR = 7'h06;

  // Format control register fields
  localparam int SWAP_BIT = 1;
  localparam int FORMAT_LSB = 3;
  localparam int LENGTH_LSB = 5;
  localparam int FRAME_POL_BIT = 7;
  localparam int BITCLK_POL_BIT = 8;

  // Clock generation register fields
  localparam int MASTER_BIT = 0;
  localparam int DIV_LSB = 2;
  localparam int SCALE_LSB = 5;
  localparam int SRC_BIT = 8;

  // Reset values
  localparam logic [8:0] FORMAT_REG_RESET = 9'h050;
  localparam logic [8:0] CLK_REG_RESET = 9'h140;

  // Master frame length in bit clocks, used as module parameter default
  localparam int FRAME_BITS_DEFAULT = 64;

  typedef enum logic [1:0] {
    FORMAT_RIGHT = 2'b00,
    FORMAT_LEFT = 2'b01,
    FORMAT_I2S = 2'b10,
    FORMAT_DSP = 2'b11
  } format_e;

  // Scaler threshold in half source ticks: 2, 3, 4, 6, 8, 12, 16, 24
  function automatic logic [5:0] scale_threshold(input logic [2:0] code);
    logic [5:0] thr;
    case (code)
      3'h0: thr = 6'h02;
      3'h1: thr = 6'h03;
      3'h2: thr = 6'h04;
      3'h3: thr = 6'h06;
      3'h4: thr = 6'h08;
      3'h5: thr = 6'h0c;
      3'h6: thr = 6'h10;
      default: thr = 6'h18;
    endcase
    return thr;
  endfunction

  // Sample length in bits for the word-length code
  function automatic logic [5:0] sample_bits(input logic [1:0] code);
    logic [5:0] n;
    case (code)
      2'h0: n = 6'h10;
      2'h1: n = 6'h14;
      2'h2: n = 6'h18;
      default: n = 6'h20;
    endcase
    return n;
  endfunction

endpackage

// file: verilog/sysclk_if.sv
// Carrier between the port engine and its internal clock scaler.
// Assumes both ends sit in the mclk domain.
`timescale 1ns/1ps
interface sysclk_if;
  logic source_pll;
  logic [2:0] scale_code;
  logic pll_tick;
  logic sys_tick;

  modport scaler (input source_pll, input scale_code, input pll_tick, output sys_tick);
  modport engine (output source_pll, output scale_code, output pll_tick, input sys_tick);
endinterface

// file: verilog/sysclk_scaler.sv
// Internal master clock scaler: turns the chosen source into a tick stream.
// Assumes pll_tick is a one-cycle enable already synchronous to mclk.
`timescale 1ns/1ps
module sysclk_scaler (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Scaler control and tick
  sysclk_if.scaler sc
);

  logic [5:0] acc;
  logic [5:0] sum;
  logic [5:0] thr;
  logic src_tick;

  assign src_tick = sc.source_pll ? sc.pll_tick : 1'b1;
  assign sum = acc + 6'h02;
  assign thr = adc_port_pkg::scale_threshold(sc.scale_code);

  // fractional divide
  // Half-tick accumulator lets divide by 1.5 average out over three source ticks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= 6'h00;
      sc.sys_tick <= 1'b0;
    end else if (src_tick) begin
      if (sum >= thr) begin
        acc <= sum - thr;
        sc.sys_tick <= 1'b1;
      end else begin
        acc <= sum;
        sc.sys_tick <= 1'b0;
      end
    end else begin
      sc.sys_tick <= 1'b0;
    end
  end

endmodule

// file: verilog/adc_audio_serial_port.sv
// Serial audio output port of a mono ADC: register pair, master clock
// generation and the bit sequencer for the four data formats.
// Assumes all pins and the register port are synchronous to mclk.
`timescale 1ns/1ps

// Function
// - master_select high drives both clocks; low makes them inputs
// - Every word goes out MSB first down to LSB; here a 32-bit DSP word with swap set loses its LSB in a 64-bit frame
// - Left-justified: MSB on first rising edge after frame transition
// - Right-justified: LSB on last rising edge before frame transition
// - I2S: MSB on second rising edge after frame transition
// - DSP mode A: MSB second edge after frame rise, right follows
// - Swap in DSP puts data one word length after the pulse
// - Swap bit selects left phase when clear, right when set
// - Format field: right, left, I2S, DSP; I2S by default
// - Word length field: 16, 20, 24, 32 bits; 24 by default
// - Master bit clock divides internal clock by 2 to 64
// - Non-integer bit-to-frame ratio may shorten last bit clock; here every frame is FRAME_BITS whole bit clocks, none shortened
// - Scaler divides source by 1, 1.5, 2, 3, 4, 6, 8, 12
// - Source select picks external clock or PLL output, PLL default
module adc_audio_serial_port #(
  parameter int FRAME_BITS = adc_port_pkg::FRAME_BITS_DEFAULT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  output logic [8:0] reg_rdata,
  // Converter samples, left aligned
  input wire logic sample_strobe,
  input wire logic [31:0] sample_word,
  // PLL tick
  input wire logic pll_tick,
  // Bit clock pin
  input wire logic bitclk_in,
  output logic bitclk_out,
  output logic bitclk_oe,
  // Frame clock pin
  input wire logic frame_sync_in,
  output logic frame_sync_output,
  output logic frame_sync_oe,
  // Data pin
  output logic sample_serial_out
);

  localparam int HALF_BITS = FRAME_BITS / 2;

  logic [8:0] fmt_reg;
  logic [8:0] clk_reg;
  logic master_select;
  logic channel_phase_swap;
  logic frame_polarity;
  logic bitclk_polarity;
  logic [2:0] bitclk_divider;
  adc_port_pkg::format_e format_select;
  logic is_dsp;
  logic [5:0] word_bits;

  // Register port
  // Writes to any other index are dropped without a sign to the host
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      fmt_reg <= adc_port_pkg::FORMAT_REG_RESET;
      clk_reg <= adc_port_pkg::CLK_REG_RESET;
    end else if (reg_write) begin
      if (reg_addr == adc_port_pkg::FORMAT_REG_ADDR) begin
        fmt_reg <= reg_wdata;
      end
      if (reg_addr == adc_port_pkg::CLK_REG_ADDR) begin
        clk_reg <= reg_wdata;
      end
    end
  end

  // Readback follows reg_addr alone, so a read needs no strobe
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 9'h000;
    end else if (reg_addr == adc_port_pkg::FORMAT_REG_ADDR) begin
      reg_rdata <= fmt_reg;
    end else if (reg_addr == adc_port_pkg::CLK_REG_ADDR) begin
      reg_rdata <= clk_reg;
    end else begin
      reg_rdata <= 9'h000;
    end
  end

  // Clock reg bit 1 is stored and read back but drives nothing
  assign master_select = clk_reg[adc_port_pkg::MASTER_BIT];
  assign bitclk_divider = clk_reg[adc_port_pkg::DIV_LSB +: 3];
  assign channel_phase_swap = fmt_reg[adc_port_pkg::SWAP_BIT];
  assign format_select = adc_port_pkg::format_e'(fmt_reg[adc_port_pkg::FORMAT_LSB +: 2]);
  assign is_dsp = (format_select == adc_port_pkg::FORMAT_DSP);
  assign word_bits = adc_port_pkg::sample_bits(fmt_reg[adc_port_pkg::LENGTH_LSB +: 2]);
  assign bitclk_polarity = fmt_reg[adc_port_pkg::BITCLK_POL_BIT];
  // frame polarity ignored in DSP
  // The pulse shape in DSP is fixed, so inverting it would only confuse the host
  assign frame_polarity = fmt_reg[adc_port_pkg::FRAME_POL_BIT] & ~is_dsp;

  // Internal clock scaler
  sysclk_if sc ();
  assign sc.source_pll = clk_reg[adc_port_pkg::SRC_BIT];
  assign sc.scale_code = clk_reg[adc_port_pkg::SCALE_LSB +: 3];
  assign sc.pll_tick = pll_tick;

  sysclk_scaler u_scaler (
    .mclk(mclk),
    .rst_b(rst_b),
    .sc(sc)
  );

  // Master clock generation
  logic [5:0] half_limit;
  logic [5:0] half_cnt;
  logic bclk_int;
  logic frame_int;
  logic [6:0] mbit;
  logic [6:0] next_mbit;
  logic next_frame;

  // divider select
  // Reserved codes hold the slowest rate rather than stop the clock
  always_comb begin
    case (bitclk_divider)
      3'h0: half_limit = 6'h00;
      3'h1: half_limit = 6'h01;
      3'h2: half_limit = 6'h03;
      3'h3: half_limit = 6'h07;
      3'h4: half_limit = 6'h0f;
      default: half_limit = 6'h1f;
    endcase
  end

  assign next_mbit = (mbit == 7'(FRAME_BITS - 1)) ? 7'h00 : mbit + 7'h01;

  always_comb begin
    case (format_select)
      // DSP pulse stands for one bit clock at frame start
      adc_port_pkg::FORMAT_DSP: next_frame = (next_mbit == 7'h00);
      // I2S left phase is the low half of the frame
      adc_port_pkg::FORMAT_I2S: next_frame = (next_mbit >= 7'(HALF_BITS));
      default: next_frame = (next_mbit < 7'(HALF_BITS));
    endcase
  end

  // whole bit clocks per frame
  // The frame always spans a whole number of bit clocks, so no short pulse appears
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      half_cnt <= 6'h00;
      bclk_int <= 1'b0;
      frame_int <= 1'b0;
      mbit <= 7'h00;
    end else if (!master_select) begin
      half_cnt <= 6'h00;
      bclk_int <= 1'b0;
      frame_int <= 1'b0;
      mbit <= 7'h00;
    end else if (sc.sys_tick) begin
      if (half_cnt >= half_limit) begin
        half_cnt <= 6'h00;
        bclk_int <= ~bclk_int;
        if (bclk_int) begin
          mbit <= next_mbit;
          frame_int <= next_frame;
        end
      end else begin
        half_cnt <= half_cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bitclk_out <= 1'b0;
      frame_sync_output <= 1'b0;
      bitclk_oe <= 1'b0;
      frame_sync_oe <= 1'b0;
    end else begin
      bitclk_out <= bclk_int ^ bitclk_polarity;
      frame_sync_output <= frame_int ^ frame_polarity;
      bitclk_oe <= master_select;
      frame_sync_oe <= master_select;
    end
  end

  // Bit sequencer
  logic lvl_b;
  logic lvl_f;
  logic prev_b;
  logic last_f;
  logic fall;
  logic trans;
  logic [6:0] k;
  logic [6:0] next_k;
  logic [6:0] half_len;
  logic [31:0] sample_hold;
  logic [31:0] word;
  logic [31:0] src_word;
  logic is_left;
  logic in_target;
  logic signed [8:0] pos;
  logic active;

  assign lvl_b = master_select ? bclk_int : (bitclk_in ^ bitclk_polarity);
  assign lvl_f = master_select ? frame_int : (frame_sync_in ^ frame_polarity);
  assign fall = prev_b & ~lvl_b;
  // pulse rise starts frame
  // Only the rising edge matters in DSP mode, so any pulse width works
  assign trans = is_dsp ? (lvl_f & ~last_f) : (lvl_f != last_f);
  assign next_k = trans ? 7'h00 : ((k == 7'h7f) ? k : k + 7'h01);
  assign src_word = trans ? sample_hold : word;
  assign is_left = (format_select == adc_port_pkg::FORMAT_I2S) ? ~lvl_f : lvl_f;
  assign in_target = channel_phase_swap ? ~is_left : is_left;

  always_comb begin
    case (format_select)
      adc_port_pkg::FORMAT_LEFT: pos = $signed({2'b00, next_k});
      adc_port_pkg::FORMAT_I2S: pos = $signed({2'b00, next_k}) - 9'sd1;
      adc_port_pkg::FORMAT_RIGHT: pos = $signed({2'b00, next_k}) - ($signed({2'b00, half_len}) - $signed({3'b000, word_bits}));
      default: pos = $signed({2'b00, next_k}) - 9'sd1 - (channel_phase_swap ? $signed({3'b000, word_bits}) : 9'sd0);
    endcase
  end

  assign active = (pos >= 9'sd0) && (pos < $signed({3'b000, word_bits})) && (is_dsp || in_target);

  // I2S tail
  // A word as long as its phase runs one slot past it, so its LSB lands in
  // the first slot of the next phase and must still come from the old word
  logic i2s_tail;
  assign i2s_tail = (format_select == adc_port_pkg::FORMAT_I2S) && trans && !in_target && (k < {1'b0, word_bits});

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sample_hold <= 32'h0000_0000;
    end else if (sample_strobe) begin
      sample_hold <= sample_word;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      prev_b <= 1'b0;
    end else begin
      prev_b <= lvl_b;
    end
  end

  // A new word is taken only at a frame edge so a sample never tears mid-frame
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      last_f <= 1'b0;
      k <= 7'h00;
      half_len <= 7'(HALF_BITS);
      word <= 32'h0000_0000;
    end else if (fall) begin
      last_f <= lvl_f;
      k <= next_k;
      if (trans) begin
        word <= sample_hold;
        if (!is_dsp) begin
          half_len <= k + 7'h01;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sample_serial_out <= 1'b0;
    end else if (fall) begin
      // Unused slots drive 0 rather than hold the last bit
      if (i2s_tail) begin
        sample_serial_out <= word[5'(31 - k)];
      end else if (active) begin
        sample_serial_out <= src_word[5'(31 - pos)];
      end else begin
        sample_serial_out <= 1'b0;
      end
    end
  end

endmodule

// file: test/adc_audio_serial_port_properties.sv
// Pin and register checks for the serial audio port.
// Assumes one mclk domain with active-low asynchronous reset.
`timescale 1ns/1ps
module adc_audio_serial_port_properties (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic reg_write,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic [8:0] reg_rdata,
  // Pins
  input wire logic bitclk_out,
  input wire logic bitclk_oe,
  input wire logic frame_sync_output,
  input wire logic frame_sync_oe,
  input wire logic sample_serial_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  wire logic clk_wr = reg_write && reg_addr == adc_port_pkg::CLK_REG_ADDR;
  property p_oe_on;
    clk_wr && reg_wdata[0] ##1 !reg_write |=> bitclk_oe && frame_sync_oe;
  endproperty
  a_oe_on: assert property (p_oe_on) else $error("drive not on");
  property p_oe_off;
    clk_wr && !reg_wdata[0] ##1 !reg_write |=> !bitclk_oe && !frame_sync_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive not off");
  property p_oe_cause;
    $changed(bitclk_oe) |-> $past(clk_wr, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("drive moved alone");
  property p_rd_none;
    (reg_addr == 7'h05) [*2] |-> reg_rdata == 9'h000;
  endproperty
  a_rd_none: assert property (p_rd_none) else $error("unmapped read");
  property p_rd_new;
    clk_wr ##1 (reg_addr == adc_port_pkg::CLK_REG_ADDR && !reg_write) [*2] |-> reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_rd_new: assert property (p_rd_new) else $error("readback stale");
  property p_data_edge;
    bitclk_oe && $past(bitclk_oe, 4) && $changed(sample_serial_out) |-> $changed(bitclk_out);
  endproperty
  a_data_edge: assert property (p_data_edge) else $error("data off edge");
  property p_frame_edge;
    bitclk_oe && $past(bitclk_oe, 4) && !$past(reg_write, 2) && $changed(frame_sync_output) |-> $changed(bitclk_out);
  endproperty
  a_frame_edge: assert property (p_frame_edge) else $error("frame off edge");
  property p_quiet;
    disable iff (1'b0) !rst_b |-> !bitclk_oe && !frame_sync_oe && !sample_serial_out;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pins busy in reset");
  c_master: cover property ($rose(bitclk_oe));
  c_frame: cover property (bitclk_oe && $changed(frame_sync_output));
  c_data: cover property ($rose(sample_serial_out));
endmodule

bind adc_audio_serial_port adc_audio_serial_port_properties chk (.mclk(mclk), .rst_b(rst_b),
  .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .bitclk_out(bitclk_out), .bitclk_oe(bitclk_oe), .frame_sync_output(frame_sync_output),
  .frame_sync_oe(frame_sync_oe), .sample_serial_out(sample_serial_out));

// file: test/audio_host_model.sv
// Host receiver: makes slave clocks and records the bits of each frame.
// Assumes the bench resolves each clock pin from device and host drives.
`timescale 1ns/1ps
module audio_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic run,
  input wire logic dsp,
  // Resolved pins
  input wire logic bclk_line,
  input wire logic frame_line,
  input wire logic data_line,
  // Host clocks and capture
  output logic host_bclk,
  output logic host_frame,
  output logic [63:0] frame_bits,
  output logic [7:0] period,
  output logic [7:0] rises
);
  logic [3:0] ph;
  logic [5:0] slot;
  logic [63:0] sh;
  logic [7:0] cnt;
  logic bclk_q;
  logic frame_q;
  wire logic [5:0] next_slot = slot + 6'h01;
  // clocks stand still when stopped; pulse one bit long
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ph <= 4'h0;
      slot <= 6'h00;
      host_bclk <= 1'b0;
      host_frame <= 1'b0;
    end else if (run) begin
      ph <= ph + 4'h1;
      if (ph == 4'h7) begin
        host_bclk <= 1'b1;
      end
      if (ph == 4'hf) begin
        host_bclk <= 1'b0;
        slot <= next_slot;
        host_frame <= dsp ? next_slot == 6'h00 : next_slot[5];
      end
    end
  end
  // Bits taken on the bit clock rise, frame latched on frame rise
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 8'h00;
      rises <= 8'h00;
      bclk_q <= 1'b0;
      frame_q <= 1'b0;
    end else begin
      bclk_q <= bclk_line;
      frame_q <= frame_line;
      cnt <= cnt + 8'h01;
      if (bclk_line && !bclk_q) begin
        sh <= {sh[62:0], data_line};
        period <= cnt + 8'h01;
        cnt <= 8'h00;
      end
      if (frame_line && !frame_q) begin
        frame_bits <= sh;
        rises <= rises + 8'h01;
      end
    end
  end
endmodule

// file: test/adc_audio_serial_port_bench.sv
// Bench for the serial audio port: register tasks and a host receiver.
// Assumes the host model latches a whole frame at each frame rise.
`timescale 1ns/1ps
module adc_audio_serial_port_bench;
  localparam logic [31:0] SAMPLE = 32'hb4e1_6a2d;
  localparam logic [23:0] W24 = SAMPLE[31:8];
  localparam logic [31:0] Z = 32'h0;
  logic mclk, rst_b, reg_write, sample_strobe, pll_tick, run, dsp;
  logic [6:0] reg_addr;
  logic [8:0] reg_wdata, reg_rdata;
  logic [31:0] sample_word;
  logic bitclk_out, bitclk_oe, frame_sync_output, frame_sync_oe, sample_serial_out;
  logic host_bclk, host_frame;
  logic [63:0] frame_bits;
  logic [7:0] period, rises;
  int num_errors, n_checks;
  wire logic bclk_line = bitclk_oe ? bitclk_out : host_bclk;
  wire logic frame_line = frame_sync_oe ? frame_sync_output : host_frame;

  adc_audio_serial_port uut (.mclk(mclk), .rst_b(rst_b), .reg_write(reg_write), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_strobe(sample_strobe), .sample_word(sample_word),
    .pll_tick(pll_tick), .bitclk_in(bclk_line), .bitclk_out(bitclk_out), .bitclk_oe(bitclk_oe),
    .frame_sync_in(frame_line), .frame_sync_output(frame_sync_output), .frame_sync_oe(frame_sync_oe),
    .sample_serial_out(sample_serial_out));
  audio_host_model host (.mclk(mclk), .rst_b(rst_b), .run(run), .dsp(dsp), .bclk_line(bclk_line),
    .frame_line(frame_line), .data_line(sample_serial_out), .host_bclk(host_bclk), .host_frame(host_frame),
    .frame_bits(frame_bits), .period(period), .rises(rises));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) pll_tick <= ~pll_tick;

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [6:0] a, input logic [8:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    repeat (2) @(posedge mclk);
    #1 check(reg_rdata, exp);
  endtask
  // Configure, let three frames pass, then compare period and frame bits
  task automatic rc(input logic [8:0] c, input logic [8:0] f, input logic [7:0] p, input logic [63:0] e);
    logic [7:0] start;
    int n;
    wr(adc_port_pkg::FORMAT_REG_ADDR, f);
    wr(adc_port_pkg::CLK_REG_ADDR, c);
    run <= !c[0];
    dsp <= f[4:3] == 2'b11;
    start = rises;
    n = 0;
    while (rises - start < 8'h03 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 40000) begin
      num_errors++;
      $display("MISMATCH t=%0t no frames", $time);
    end
    #1 check(period, p);
    check(frame_bits, e);
    $display("Case clk %h fmt %h done", c, f);
  endtask
  task automatic results;
    $display("Checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #2_500_000;
    num_errors++;
    $display("MISMATCH t=%0t watchdog", $time);
    results();
  end
  initial begin
    rst_b = 1'b0;
    reg_write = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 9'h000;
    sample_strobe = 1'b0;
    sample_word = SAMPLE;
    pll_tick = 1'b0;
    run = 1'b1;
    dsp = 1'b0;
    num_errors = 0;
    n_checks = 0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
    rd(7'h04, 9'h050);
    rd(7'h06, 9'h140);
    wr(7'h05, 9'h1ff);
    rd(7'h05, 9'h000);
    rd(7'h04, 9'h050);
    @(posedge mclk);
    sample_strobe <= 1'b1;
    @(posedge mclk);
    sample_strobe <= 1'b0;
    rc(9'h140, 9'h050, 8'h10, {Z, 1'b0, W24, 7'h0});
    rc(9'h140, 9'h048, 8'h10, {W24, 8'h0, Z});
    rc(9'h140, 9'h040, 8'h10, {8'h0, W24, Z});
    rc(9'h140, 9'h058, 8'h10, {1'b0, W24, 39'h0});
    rc(9'h140, 9'h05a, 8'h10, {25'h0, W24, 15'h0});
    rc(9'h140, 9'h052, 8'h10, {1'b0, W24, 7'h0, Z});
    rc(9'h140, 9'h010, 8'h10, {Z, 1'b0, SAMPLE[31:16], 15'h0});
    rc(9'h140, 9'h030, 8'h10, {Z, 1'b0, SAMPLE[31:12], 11'h0});
    rc(9'h140, 9'h070, 8'h10, {SAMPLE[0], 31'h0, 1'b0, SAMPLE[31:1]});
    rc(9'h041, 9'h050, 8'h04, {Z, 1'b0, W24, 7'h0});
    rc(9'h045, 9'h058, 8'h08, {1'b0, W24, 39'h0});
    rc(9'h051, 9'h048, 8'h40, {W24, 8'h0, Z});
    rc(9'h061, 9'h040, 8'h06, {8'h0, W24, Z});
    rc(9'h0e1, 9'h050, 8'h18, {Z, 1'b0, W24, 7'h0});
    rc(9'h141, 9'h050, 8'h08, {Z, 1'b0, W24, 7'h0});
    rc(9'h041, 9'h0d0, 8'h04, {1'b0, W24, 7'h0, Z});
    rc(9'h041, 9'h150, 8'h04, {Z, 1'b0, W24, 7'h0});
    results();
  end
endmodule
